/* rtl/bib_regs.sv */
// bus info block registers behind a classic wishbone slave
//
// Contract
// - header register at 18h, three fields
// - header size and span reset to zero
// - read-only 1Ch returns ascii 1394
// - bus id presented as quadlet zero
// - bus options at 20h, quadlet one
// - bits 31,30 rw flags, reset zero
// - bits 29,28 rw flags, reset zero
// - flags read zero until software writes
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
module bib_regs (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // wishbone slave
  input  wire bib_regs_pkg::wb_req_t wb_req,
  output      bib_regs_pkg::wb_rsp_t wb_rsp,
  // bus info block presentation
  output      logic [31:0]           bib_quadlet0,
  output      logic [31:0]           bib_quadlet1,
  output      logic [31:0]           rom_header,
  output      logic                  link_active_enable
);

  // ****************************************
  // bus decode
  // ****************************************
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic [31:0] header_r;
  logic [31:0] options_r;
  logic [31:0] ctrl_r;
  logic [31:0] bus_id_r;
  logic        req;
  logic        wr;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel, input logic [31:0] rw_mask);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & rw_mask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction

  assign req      = wb_req.cyc & wb_req.stb;
  // writes land at the edge where the master sees ack
  assign wr       = req & wb_req.we & ack_r;
  assign ack_nxt  = req & ~ack_r;

  // one ack per request, one cycle after it is taken
  a_ack_answer: assert property (@(posedge clk) disable iff (reset)
    (req && !ack_r) |=> wb_rsp.ack) else $error("request not answered in one cycle");

  always_comb begin
    rdat_nxt = bib_regs_pkg::ZERO_WORD;
    if (hit(wb_req.adr, bib_regs_pkg::OFS_HEADER)) begin
      rdat_nxt = header_r;
    end else if (hit(wb_req.adr, bib_regs_pkg::OFS_BUS_ID)) begin
      rdat_nxt = bus_id_r;
    end else if (hit(wb_req.adr, bib_regs_pkg::OFS_OPTIONS)) begin
      rdat_nxt = options_r;
    end else if (hit(wb_req.adr, bib_regs_pkg::OFS_CTRL_SET) || hit(wb_req.adr, bib_regs_pkg::OFS_CTRL_CLR)) begin
      rdat_nxt = ctrl_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_r  <= 1'b0;
      rdat_r <= bib_regs_pkg::ZERO_WORD;
    end else begin
      ack_r  <= ack_nxt;
      rdat_r <= ack_nxt ? rdat_nxt : rdat_r;
    end
  end

  // unmapped offsets read as zero
  a_unmapped_read: assert property (@(posedge clk) disable iff (reset)
    (ack_nxt && !wb_req.we && !hit(wb_req.adr, bib_regs_pkg::OFS_HEADER)
     && !hit(wb_req.adr, bib_regs_pkg::OFS_BUS_ID) && !hit(wb_req.adr, bib_regs_pkg::OFS_OPTIONS)
     && !hit(wb_req.adr, bib_regs_pkg::OFS_CTRL_SET) && !hit(wb_req.adr, bib_regs_pkg::OFS_CTRL_CLR))
    |=> wb_rsp.dat == bib_regs_pkg::ZERO_WORD) else $error("unmapped read not zero");

  // ****************************************
  // configuration rom header
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      header_r <= bib_regs_pkg::HEADER_RESET;
    end else if (wr && hit(wb_req.adr, bib_regs_pkg::OFS_HEADER)) begin
      header_r <= lane_merge(header_r, wb_req.dat, wb_req.sel, '1);
    end
  end

  // check value lanes land, header holds otherwise
  a_crc_write: assert property (@(posedge clk) disable iff (reset)
    (wr && wb_req.sel[1] && wb_req.sel[0] && hit(wb_req.adr, bib_regs_pkg::OFS_HEADER))
    |=> header_r[bib_regs_pkg::HDR_SPAN_LSB-1:0] == $past(wb_req.dat[bib_regs_pkg::HDR_SPAN_LSB-1:0]))
    else $error("header check value not stored");
  a_header_hold: assert property (@(posedge clk) disable iff (reset)
    !(wr && hit(wb_req.adr, bib_regs_pkg::OFS_HEADER)) |=> $stable(header_r))
    else $error("header changed without write");

  // ****************************************
  // bus identification, constant
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_id_r <= bib_regs_pkg::BUS_ID_VALUE;
    end else begin
      bus_id_r <= bib_regs_pkg::BUS_ID_VALUE;
    end
  end

  // ****************************************
  // bus options
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      options_r <= bib_regs_pkg::OPTIONS_RESET;
    end else if (wr && hit(wb_req.adr, bib_regs_pkg::OFS_OPTIONS)) begin
      options_r <= lane_merge(options_r, wb_req.dat, wb_req.sel, bib_regs_pkg::OPTIONS_RW_MASK)
                   | bib_regs_pkg::OPTIONS_RO_BITS;
    end
  end

  // capability flags take the written lane
  a_caps_write: assert property (@(posedge clk) disable iff (reset)
    (wr && wb_req.sel[3] && hit(wb_req.adr, bib_regs_pkg::OFS_OPTIONS))
    |=> options_r[bib_regs_pkg::CAP_MSB:bib_regs_pkg::CAP_MSB-1]
        == $past(wb_req.dat[bib_regs_pkg::CAP_MSB:bib_regs_pkg::CAP_MSB-1]))
    else $error("upper capability flags not stored");
  a_isoc_write: assert property (@(posedge clk) disable iff (reset)
    (wr && wb_req.sel[3] && hit(wb_req.adr, bib_regs_pkg::OFS_OPTIONS))
    |=> options_r[bib_regs_pkg::CAP_LSB+1:bib_regs_pkg::CAP_LSB]
        == $past(wb_req.dat[bib_regs_pkg::CAP_LSB+1:bib_regs_pkg::CAP_LSB]))
    else $error("lower capability flags not stored");

  // ****************************************
  // link enable, set and clear ports
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= bib_regs_pkg::CTRL_RESET;
    end else if (wr && hit(wb_req.adr, bib_regs_pkg::OFS_CTRL_SET)) begin
      ctrl_r <= ctrl_r | (lane_merge(bib_regs_pkg::ZERO_WORD, wb_req.dat, wb_req.sel, bib_regs_pkg::CTRL_RW_MASK));
    end else if (wr && hit(wb_req.adr, bib_regs_pkg::OFS_CTRL_CLR)) begin
      ctrl_r <= ctrl_r & ~(lane_merge(bib_regs_pkg::ZERO_WORD, wb_req.dat, wb_req.sel, bib_regs_pkg::CTRL_RW_MASK));
    end
  end

  // link enable image follows set and clear writes
  a_link_set: assert property (@(posedge clk) disable iff (reset)
    (wr && hit(wb_req.adr, bib_regs_pkg::OFS_CTRL_SET) && wb_req.sel[2] && wb_req.dat[bib_regs_pkg::LINK_EN_BIT])
    |=> ##1 link_active_enable) else $error("link enable not set");
  a_link_clear: assert property (@(posedge clk) disable iff (reset)
    (wr && hit(wb_req.adr, bib_regs_pkg::OFS_CTRL_CLR) && wb_req.sel[2] && wb_req.dat[bib_regs_pkg::LINK_EN_BIT])
    |=> ##1 !link_active_enable) else $error("link enable not cleared");

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      bib_quadlet0       <= bib_regs_pkg::BUS_ID_VALUE;
      bib_quadlet1       <= bib_regs_pkg::OPTIONS_RESET;
      rom_header         <= bib_regs_pkg::HEADER_RESET;
      link_active_enable <= 1'b0;
    end else begin
      bib_quadlet0       <= bus_id_r;
      bib_quadlet1       <= options_r;
      rom_header         <= header_r;
      // fields are trusted valid once this is set
      link_active_enable <= ctrl_r[bib_regs_pkg::LINK_EN_BIT];
    end
  end

  assign wb_rsp.ack = ack_r;
  assign wb_rsp.dat = rdat_r;

  // ****************************************
  // assertions
  // ****************************************
  a_busid_const: assert property (@(posedge clk) disable iff (reset)
    bus_id_r == bib_regs_pkg::BUS_ID_VALUE) else $error("bus id register lost its constant");
  a_busid_read: assert property (@(posedge clk) disable iff (reset)
    (ack_nxt && !wb_req.we && hit(wb_req.adr, bib_regs_pkg::OFS_BUS_ID))
    |=> (wb_rsp.ack && wb_rsp.dat == bib_regs_pkg::BUS_ID_VALUE)) else $error("bus id read wrong");
  a_busid_write: assert property (@(posedge clk) disable iff (reset)
    (wr && hit(wb_req.adr, bib_regs_pkg::OFS_BUS_ID)) |=> ##1 bib_quadlet0 == bib_regs_pkg::BUS_ID_VALUE)
    else $error("bus id changed by a write");
  a_header_reset: assert property (@(posedge clk)
    reset |=> header_r[bib_regs_pkg::HDR_INFO_MSB:bib_regs_pkg::HDR_SPAN_LSB] == 16'h0000)
    else $error("header size or span not cleared");
  a_header_write: assert property (@(posedge clk) disable iff (reset)
    (wr && wb_req.sel == 4'hf && hit(wb_req.adr, bib_regs_pkg::OFS_HEADER))
    |=> ##1 rom_header == $past(wb_req.dat, 2)) else $error("header write not stored");
  a_caps_reset: assert property (@(posedge clk)
    reset |=> options_r[bib_regs_pkg::CAP_MSB:bib_regs_pkg::CAP_LSB] == 4'h0)
    else $error("capability flags not cleared");
  a_caps_hold: assert property (@(posedge clk) disable iff (reset)
    !(wr && hit(wb_req.adr, bib_regs_pkg::OFS_OPTIONS))
    |=> $stable(options_r[bib_regs_pkg::CAP_MSB:bib_regs_pkg::CAP_LSB]))
    else $error("capability flags changed without write");
  a_options_view: assert property (@(posedge clk) disable iff (reset)
    ##1 (bib_quadlet1 == $past(options_r)
         && (bib_quadlet1 & ~bib_regs_pkg::OPTIONS_RW_MASK) == bib_regs_pkg::OPTIONS_RO_BITS))
    else $error("bus options quadlet wrong");
  a_ack_pulse: assert property (@(posedge clk) disable iff (reset)
    wb_rsp.ack |=> !wb_rsp.ack) else $error("ack held beyond one cycle");

  c_header_write: cover property (@(posedge clk) wr && hit(wb_req.adr, bib_regs_pkg::OFS_HEADER));
  c_caps_set: cover property (@(posedge clk) options_r[bib_regs_pkg::CAP_MSB:bib_regs_pkg::CAP_LSB] == 4'hf);
  c_link_on: cover property (@(posedge clk) $rose(link_active_enable));
  c_busid_read: cover property (@(posedge clk) wb_rsp.ack && wb_rsp.dat == bib_regs_pkg::BUS_ID_VALUE);
  c_busid_write: cover property (@(posedge clk) wr && hit(wb_req.adr, bib_regs_pkg::OFS_BUS_ID));

endmodule

/* rtl/bib_regs_pkg.sv */
// constants and carriers for the bus info block register bank
package bib_regs_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_HEADER   = 8'h18;
  localparam logic [7:0] OFS_BUS_ID   = 8'h1c;
  localparam logic [7:0] OFS_OPTIONS  = 8'h20;
  localparam logic [7:0] OFS_CTRL_SET = 8'h50;
  localparam logic [7:0] OFS_CTRL_CLR = 8'h54;

  // ****************************************
  // fixed values and reset values
  // ****************************************
  localparam logic [31:0] BUS_ID_VALUE  = 32'h31333934;
  localparam logic [31:0] HEADER_RESET  = 32'h00000000;
  localparam logic [31:0] OPTIONS_RESET = 32'h0000a002;
  localparam logic [31:0] CTRL_RESET    = 32'h00000000;
  localparam logic [31:0] ZERO_WORD     = 32'h00000000;

  // ****************************************
  // field layout
  // ****************************************
  localparam int HDR_INFO_MSB   = 31;
  localparam int HDR_SPAN_LSB   = 16;
  localparam int CAP_MSB        = 31;
  localparam int CAP_LSB        = 28;
  localparam int LINK_EN_BIT    = 17;
  // writable bits of bus options: flags, pmc, clock accuracy, max request, generation
  localparam logic [31:0] OPTIONS_RW_MASK = 32'hf8fff0c0;
  localparam logic [31:0] OPTIONS_RO_BITS = 32'h00000002;
  localparam logic [31:0] CTRL_RW_MASK    = 32'h00020000;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;
endpackage

/* verification/test_bib_regs.sv */
// self-checking bench for the bus info block register bank
`timescale 1ns/1ps
module test_bib_regs;
  logic                  clk;
  logic                  reset;
  bib_regs_pkg::wb_req_t wb_req;
  bib_regs_pkg::wb_rsp_t wb_rsp;
  logic [31:0]           bib_quadlet0;
  logic [31:0]           bib_quadlet1;
  logic [31:0]           rom_header;
  logic                  link_active_enable;
  logic [31:0]           rv;
  int                    fails;
  int                    check_count;

  bib_regs i_dut (
    .clk                (clk),
    .reset              (reset),
    .wb_req             (wb_req),
    .wb_rsp             (wb_rsp),
    .bib_quadlet0       (bib_quadlet0),
    .bib_quadlet1       (bib_quadlet1),
    .rom_header         (rom_header),
    .link_active_enable (link_active_enable)
  );

  always #5 clk = ~clk;

  // ****************************************
  // shared helpers
  // ****************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one classic cycle; ack seen at the edge ends it
  task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] wd);
    int n;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: wd};
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (wb_rsp.ack === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      $display("CHECK FAILED ack expected 1 seen 0");
      finish_test();
    end
    rv = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    bus(1'b0, 8'h18, 4'hf, 32'h0);
    chk("hdr size span", 32'h0, {16'h0, rv[31:16]});
    chk("hdr image rst", 32'h0, {16'h0, rom_header[31:16]});
    bus(1'b0, 8'h1c, 4'hf, 32'h0);
    chk("bus id", bib_regs_pkg::BUS_ID_VALUE, rv);
    bus(1'b0, 8'h20, 4'hf, 32'h0);
    chk("options rst", 32'h0000a002, rv & 32'hff00ff0f);
    chk("flags rst", 32'h0, {28'h0, rv[31:28]});
    chk("quadlet0", bib_regs_pkg::BUS_ID_VALUE, bib_quadlet0);
    chk("quadlet1 rst", 32'h0000a002, bib_quadlet1 & 32'hff00ff0f);
    chk("link rst", 32'h0, {31'h0, link_active_enable});
  endtask

  task automatic t_header;
    bus(1'b1, 8'h18, 4'hf, 32'h04a5c3d2);
    bus(1'b0, 8'h18, 4'hf, 32'h0);
    chk("hdr rw", 32'h04a5c3d2, rv);
    bus(1'b1, 8'h18, 4'h4, 32'hffee7788);
    bus(1'b0, 8'h18, 4'hf, 32'h0);
    chk("hdr span lane", 32'h04eec3d2, rv);
    repeat (3) @(posedge clk);
    chk("hdr image", 32'h04eec3d2, rom_header);
  endtask

  task automatic t_bus_id;
    bus(1'b1, 8'h1c, 4'hf, 32'hffffffff);
    bus(1'b0, 8'h1c, 4'hf, 32'h0);
    chk("bus id wr", bib_regs_pkg::BUS_ID_VALUE, rv);
    repeat (3) @(posedge clk);
    chk("quadlet0 wr", bib_regs_pkg::BUS_ID_VALUE, bib_quadlet0);
  endtask

  // each capability flag alone, reserved bits written too
  task automatic t_flags;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h20, 4'hf, (32'h10000000 << i) | 32'h0700003f);
      bus(1'b0, 8'h20, 4'hf, 32'h0);
      chk("flag bits", 32'h1 << i, {28'h0, rv[31:28]});
      chk("options fixed", 32'h00000002, rv & 32'h07000f3f);
      repeat (3) @(posedge clk);
      chk("quadlet1 flag", 32'h1 << i, {28'h0, bib_quadlet1[31:28]});
    end
  endtask

  // fields already valid here; check value rewritten while linked
  task automatic t_link;
    bus(1'b1, 8'h50, 4'hf, 32'h00020000);
    repeat (3) @(posedge clk);
    chk("link set", 32'h1, {31'h0, link_active_enable});
    bus(1'b0, 8'h54, 4'hf, 32'h0);
    chk("ctrl read", 32'h00020000, rv);
    bus(1'b1, 8'h18, 4'h3, 32'hffffbeef);
    repeat (3) @(posedge clk);
    chk("crc live", 32'h04eebeef, rom_header);
    chk("link kept", 32'h1, {31'h0, link_active_enable});
    bus(1'b1, 8'h54, 4'hf, 32'h00020000);
    repeat (3) @(posedge clk);
    chk("link clear", 32'h0, {31'h0, link_active_enable});
    bus(1'b0, 8'h40, 4'hf, 32'h0);
    chk("unmapped", 32'h0, rv);
  endtask

  // reset in mid-run clears fields, flags and link enable
  task automatic t_rerun_reset;
    bus(1'b1, 8'h20, 4'h8, 32'hf0000000);
    bus(1'b1, 8'h50, 4'hf, 32'h00020000);
    bus(1'b0, 8'h20, 4'hf, 32'h0);
    chk("flags all", 32'hf, {28'h0, rv[31:28]});
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(1'b0, 8'h18, 4'hf, 32'h0);
    chk("hdr rst again", 32'h0, {16'h0, rv[31:16]});
    bus(1'b0, 8'h20, 4'hf, 32'h0);
    chk("flags rst again", 32'h0, {28'h0, rv[31:28]});
    chk("quadlet1 rst again", 32'h0, {28'h0, bib_quadlet1[31:28]});
    chk("link rst again", 32'h0, {31'h0, link_active_enable});
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    wb_req = '0;
    fails = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_header();
    t_bus_id();
    t_flags();
    t_link();
    t_rerun_reset();
    finish_test();
  end
endmodule
